// >>> hw/wwd_delay_timer.sv
// Down counter that times the reset delay and the fault hold period.
`timescale 1ns/100ps
`default_nettype none
module wwd_delay_timer #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic         clr,
    input  wire logic [W-1:0] load_val,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_q;

    // Loads at least one cycle so a zero value still completes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= (load_val == '0) ? W'(1) : load_val;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == W'(1));
endmodule // wwd_delay_timer
`default_nettype wire

// >>> hw/wwd_params.svh
// Constants of the window watchdog reset supervisor: offsets, fields, reset values and timing.
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define WWD_OFS_CAP_RST   12'h000
`define WWD_OFS_CAP_WDU   12'h004
`define WWD_OFS_STATUS    12'h008
`define WWD_OFS_IRQ_STAT  12'h00C
`define WWD_OFS_IRQ_CLR   12'h010
`define WWD_OFS_IRQ_EN    12'h014

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define WWD_IRQ_W          4
`define WWD_IRQ_RST_ASSERT 0
`define WWD_IRQ_RST_REL    1
`define WWD_IRQ_WD_EARLY   2
`define WWD_IRQ_WD_LATE    3
`define WWD_CAP_RST_RESET  32'h0000_0100
`define WWD_CAP_WDU_RESET  32'h0000_1000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WWD_CLK_HZ           25000000
`define WWD_TRST_PULLUP_US   200000
`define WWD_TRST_OPEN_US     10000
`define WWD_WINDOW_UPPER_BOUND_PULLUP_US   1000000
`define WWD_WINDOW_UPPER_BOUND_OPEN_US     100000
`define WWD_CYC_PER_US       (`WWD_CLK_HZ / 1000000)

`endif

// >>> hw/wwd_pkg.sv
// Types of the window watchdog reset supervisor.
package wwd_pkg;

    typedef enum logic [1:0] {
        STRAP_CAP    = 2'h0,
        STRAP_PULLUP = 2'h1,
        STRAP_OPEN   = 2'h2
    } wwd_strap_t;

    typedef enum logic [2:0] {
        SUP_HOLD  = 3'h1,
        SUP_DELAY = 3'h2,
        SUP_RUN   = 3'h4
    } wwd_sup_t;

    typedef enum logic [2:0] {
        WD_OFF   = 3'h1,
        WD_WIN   = 3'h2,
        WD_FAULT = 3'h4
    } wwd_wd_t;

endpackage

// >>> hw/wwd_top.sv
// Window watchdog reset supervisor with APB registers and interrupt.
`timescale 1ns/100ps
`default_nettype none
`include "wwd_params.svh"
module wwd_top import wwd_pkg::*; #(
    parameter logic [31:0] RST_PULLUP_CYC = 32'(`WWD_TRST_PULLUP_US * `WWD_CYC_PER_US),
    parameter logic [31:0] RST_OPEN_CYC   = 32'(`WWD_TRST_OPEN_US * `WWD_CYC_PER_US),
    parameter logic [31:0] WDU_PULLUP_CYC = 32'(`WWD_WINDOW_UPPER_BOUND_PULLUP_US * `WWD_CYC_PER_US),
    parameter logic [31:0] WDU_OPEN_CYC   = 32'(`WWD_WINDOW_UPPER_BOUND_OPEN_US * `WWD_CYC_PER_US)
) (
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        POWER_ON_OK,
    input  wire logic        RAIL_UNDERVOLTAGE,
    input  wire logic        RAIL_OVERVOLTAGE,
    input  wire logic        WATCHDOG_KICK_INPUT,
    input  wire logic        WINDOW_SELECT_0,
    input  wire logic        WINDOW_SELECT_1,
    input  wire wwd_strap_t  RESET_DELAY_PIN,
    input  wire wwd_strap_t  WATCHDOG_TIMING_PIN,
    input  wire logic        RESET_OUT_I,
    output logic             RESET_OUT_O,
    output logic             RESET_OUT_OE,
    input  wire logic        WATCHDOG_FAULT_OUTPUT_I,
    output logic             WATCHDOG_FAULT_OUTPUT_O,
    output logic             WATCHDOG_FAULT_OUTPUT_OE,
    output logic             IRQ
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [31:0]            cap_rst_q;
    logic [31:0]            cap_wdu_q;
    logic [`WWD_IRQ_W-1:0]  irq_en_q;
    logic [`WWD_IRQ_W-1:0]  irq_stat_q;
    logic [`WWD_IRQ_W-1:0]  irq_ev;
    logic [`WWD_IRQ_W-1:0]  irq_clr;
    logic [31:0]            prdata_q;
    logic                   irq_q;
    logic [31:0]            wr_mask;
    logic                   wr_en;
    logic                   rd_setup;
    logic                   addr_hit;
    logic [31:0]            rd_value;

    wwd_sup_t               sup_q;
    wwd_sup_t               sup_d;
    wwd_wd_t                wd_q;
    wwd_wd_t                wd_d;
    logic                   rst_oe_q;
    logic                   wdo_oe_q;
    logic                   rail_ok;
    logic [31:0]            rst_delay;
    logic                   rst_tmr_load;
    logic                   rst_tmr_done;
    logic                   flt_tmr_load;
    logic                   flt_tmr_clr;
    logic                   flt_tmr_done;

    logic [31:0]            win_lower;
    logic [31:0]            win_upper;
    logic                   wd_disabled;
    logic [31:0]            wcnt_q;
    logic                   kick_prev_q;
    logic                   kick_fall;
    logic                   kick_taken;
    logic                   early_kick;
    logic                   late_window;
    logic                   win_restart;

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    assign wr_en    = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

    always_comb begin
        case (PADDR)
            `WWD_OFS_CAP_RST,
            `WWD_OFS_CAP_WDU,
            `WWD_OFS_STATUS,
            `WWD_OFS_IRQ_STAT,
            `WWD_OFS_IRQ_CLR,
            `WWD_OFS_IRQ_EN: addr_hit = 1'b1;
            default:         addr_hit = 1'b0;
        endcase
    end

    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            assign wr_mask[8*b +: 8] = {8{PSTRB[b]}};
        end
    endgenerate

    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_hit;

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            cap_rst_q <= `WWD_CAP_RST_RESET;
        end else if (wr_en && PADDR == `WWD_OFS_CAP_RST) begin
            cap_rst_q <= (cap_rst_q & ~wr_mask) | (PWDATA & wr_mask);
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            cap_wdu_q <= `WWD_CAP_WDU_RESET;
        end else if (wr_en && PADDR == `WWD_OFS_CAP_WDU) begin
            cap_wdu_q <= (cap_wdu_q & ~wr_mask) | (PWDATA & wr_mask);
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_en_q <= '0;
        end else if (wr_en && PADDR == `WWD_OFS_IRQ_EN && PSTRB[0]) begin
            irq_en_q <= PWDATA[`WWD_IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always_comb begin
        rd_value = 32'h0000_0000;
        case (PADDR)
            `WWD_OFS_CAP_RST:  rd_value = cap_rst_q;
            `WWD_OFS_CAP_WDU:  rd_value = cap_wdu_q;
            `WWD_OFS_STATUS:   rd_value = {23'h00_0000, WATCHDOG_KICK_INPUT, WATCHDOG_FAULT_OUTPUT_I,
                                           RESET_OUT_I, wd_disabled, wdo_oe_q, rst_oe_q,
                                           RAIL_OVERVOLTAGE, RAIL_UNDERVOLTAGE, POWER_ON_OK};
            `WWD_OFS_IRQ_STAT: rd_value = {28'h000_0000, irq_stat_q};
            `WWD_OFS_IRQ_EN:   rd_value = {28'h000_0000, irq_en_q};
            default:           rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= rd_value;
        end
    end

    assign PRDATA = prdata_q;

    // ------------------------------------------------------------------------
    // Supervisor state machine
    // ------------------------------------------------------------------------
    assign rail_ok = POWER_ON_OK & ~RAIL_UNDERVOLTAGE & ~RAIL_OVERVOLTAGE;

    always_comb begin
        case (RESET_DELAY_PIN)
            STRAP_CAP:    rst_delay = cap_rst_q;
            STRAP_PULLUP: rst_delay = RST_PULLUP_CYC;
            default:      rst_delay = RST_OPEN_CYC;
        endcase
    end

    always_comb begin
        sup_d = sup_q;
        case (sup_q)
            SUP_HOLD: begin
                if (rail_ok) begin
                    sup_d = SUP_DELAY;
                end
            end
            SUP_DELAY: begin
                if (!rail_ok) begin
                    sup_d = SUP_HOLD;
                end else if (rst_tmr_done) begin
                    sup_d = SUP_RUN;
                end
            end
            SUP_RUN: begin
                if (!rail_ok) begin
                    sup_d = SUP_HOLD;
                end
            end
            default: sup_d = SUP_HOLD;
        endcase
    end

    assign rst_tmr_load = (sup_q == SUP_HOLD) & rail_ok;

    wwd_delay_timer #(
        .W        (32)
    ) u_rst_timer (
        .clk      (REF_CLK),
        .rst_n    (NRST),
        .load     (rst_tmr_load),
        .clr      (~rail_ok),
        .load_val (rst_delay),
        .busy     (),
        .done     (rst_tmr_done)
    );

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sup_q    <= SUP_HOLD;
            rst_oe_q <= 1'b1;
        end else begin
            sup_q    <= sup_d;
            rst_oe_q <= (sup_d != SUP_RUN);
        end
    end

    assign RESET_OUT_O  = 1'b0;
    assign RESET_OUT_OE = rst_oe_q;

    // ------------------------------------------------------------------------
    // Watchdog window
    // ------------------------------------------------------------------------
    wwd_window_decode #(
        .UPPER_PULLUP (WDU_PULLUP_CYC),
        .UPPER_OPEN   (WDU_OPEN_CYC)
    ) u_decode (
        .sel0         (WINDOW_SELECT_0),
        .sel1         (WINDOW_SELECT_1),
        .timing_mode  (WATCHDOG_TIMING_PIN),
        .cap_upper    (cap_wdu_q),
        .lower        (win_lower),
        .upper        (win_upper),
        .disabled     (wd_disabled)
    );

    assign kick_fall   = kick_prev_q & ~WATCHDOG_KICK_INPUT;
    assign kick_taken  = kick_fall & (wd_q == WD_WIN) & (sup_q == SUP_RUN) & ~wd_disabled;
    assign early_kick  = kick_taken & (wcnt_q < win_lower);
    assign late_window = (wd_q == WD_WIN) & ~kick_taken & (wcnt_q + 32'd1 >= win_upper);

    always_comb begin
        wd_d = wd_q;
        case (wd_q)
            WD_OFF: begin
                if (sup_d == SUP_RUN && !wd_disabled) begin
                    wd_d = WD_WIN;
                end
            end
            WD_WIN: begin
                if (sup_d != SUP_RUN || wd_disabled) begin
                    wd_d = WD_OFF;
                end else if (early_kick || late_window) begin
                    wd_d = WD_FAULT;
                end
            end
            WD_FAULT: begin
                if (sup_d != SUP_RUN) begin
                    wd_d = WD_OFF;
                end else if (flt_tmr_done) begin
                    wd_d = wd_disabled ? WD_OFF : WD_WIN;
                end
            end
            default: wd_d = WD_OFF;
        endcase
    end

    assign flt_tmr_load = (wd_q == WD_WIN) & (wd_d == WD_FAULT);
    assign flt_tmr_clr  = (wd_d != WD_FAULT);
    assign win_restart  = (wd_d == WD_WIN) & ((wd_q != WD_WIN) | kick_taken);

    wwd_delay_timer #(
        .W        (32)
    ) u_flt_timer (
        .clk      (REF_CLK),
        .rst_n    (NRST),
        .load     (flt_tmr_load),
        .clr      (flt_tmr_clr),
        .load_val (rst_delay),
        .busy     (),
        .done     (flt_tmr_done)
    );

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            kick_prev_q <= 1'b1;
        end else begin
            kick_prev_q <= WATCHDOG_KICK_INPUT;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wcnt_q <= 32'h0000_0000;
        end else if (win_restart || wd_d != WD_WIN) begin
            wcnt_q <= 32'h0000_0000;
        end else begin
            wcnt_q <= wcnt_q + 32'd1;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wd_q     <= WD_OFF;
            wdo_oe_q <= 1'b0;
        end else begin
            wd_q     <= wd_d;
            wdo_oe_q <= (wd_d == WD_FAULT) & (sup_d == SUP_RUN);
        end
    end

    assign WATCHDOG_FAULT_OUTPUT_O  = 1'b0;
    assign WATCHDOG_FAULT_OUTPUT_OE = wdo_oe_q;

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    always_comb begin
        irq_ev = '0;
        irq_ev[`WWD_IRQ_RST_ASSERT] = (sup_q == SUP_RUN) & (sup_d != SUP_RUN);
        irq_ev[`WWD_IRQ_RST_REL]    = (sup_q != SUP_RUN) & (sup_d == SUP_RUN);
        irq_ev[`WWD_IRQ_WD_EARLY]   = flt_tmr_load & early_kick;
        irq_ev[`WWD_IRQ_WD_LATE]    = flt_tmr_load & ~early_kick;
    end

    assign irq_clr = (wr_en && PADDR == `WWD_OFS_IRQ_CLR && PSTRB[0]) ? PWDATA[`WWD_IRQ_W-1:0] : '0;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_en_q);
        end
    end

    assign IRQ = irq_q;

endmodule // wwd_top
`default_nettype wire

// >>> hw/wwd_window_decode.sv
// Decodes select inputs and timing pin state into window bounds and disable.
`timescale 1ns/100ps
`default_nettype none
module wwd_window_decode import wwd_pkg::*; #(
    parameter logic [31:0] UPPER_PULLUP = 32'h0000_0001,
    parameter logic [31:0] UPPER_OPEN   = 32'h0000_0001
) (
    input  wire logic        sel0,
    input  wire logic        sel1,
    input  wire wwd_strap_t  timing_mode,
    input  wire logic [31:0] cap_upper,
    output logic [31:0]      lower,
    output logic [31:0]      upper,
    output logic             disabled
);
    logic [1:0] shift;

    always_comb begin
        case (timing_mode)
            STRAP_CAP:    upper = cap_upper;
            STRAP_PULLUP: upper = UPPER_PULLUP;
            default:      upper = UPPER_OPEN;
        endcase
    end

    always_comb begin
        disabled = 1'b0;
        case ({sel1, sel0})
            2'b00:   shift = 2'd3;
            2'b01: begin
                shift    = 2'd3;
                disabled = 1'b1;
            end
            2'b10:   shift = 2'd1;
            default: shift = 2'd2;
        endcase
    end

    assign lower = upper >> shift;
endmodule // wwd_window_decode
`default_nettype wire

// >>> verif/wwd_host_model.sv
// Host processor that services the watchdog kick input.
`timescale 1ns/100ps
`default_nettype none
module wwd_host_model (
    input  wire logic        clk,
    input  wire logic        rst_pin,
    input  wire logic        enable,
    input  wire logic [15:0] period,
    output logic             kick
);
    logic [15:0] cnt_q;
    always_ff @(posedge clk or negedge rst_pin) begin
        if (!rst_pin) begin
            cnt_q <= 16'h0000;
            kick  <= 1'b1;
        end else if (!enable) begin
            cnt_q <= 16'h0000;
            kick  <= 1'b1;
        end else if (cnt_q == period - 16'h0001) begin
            cnt_q <= 16'h0000;
            kick  <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'h0001) kick <= 1'b1;
        end
    end
endmodule // wwd_host_model
`default_nettype wire

// >>> verif/wwd_top_asserts.sv
// Port checker of the window watchdog reset supervisor.
`timescale 1ns/100ps
`default_nettype none
module wwd_top_asserts import wwd_pkg::*; #(
    parameter logic [31:0] RST_PULLUP_CYC = 32'h0000_0040,
    parameter logic [31:0] RST_OPEN_CYC   = 32'h0000_0020,
    parameter logic [31:0] WDU_PULLUP_CYC = 32'h0000_0200,
    parameter logic [31:0] WDU_OPEN_CYC   = 32'h0000_0100
) (
    input wire logic       REF_CLK,
    input wire logic       NRST,
    input wire logic       POWER_ON_OK,
    input wire logic       RAIL_UNDERVOLTAGE,
    input wire logic       RAIL_OVERVOLTAGE,
    input wire logic       WATCHDOG_KICK_INPUT,
    input wire logic       WINDOW_SELECT_0,
    input wire logic       WINDOW_SELECT_1,
    input wire wwd_strap_t RESET_DELAY_PIN,
    input wire wwd_strap_t WATCHDOG_TIMING_PIN,
    input wire logic       RESET_OUT_OE,
    input wire logic       WATCHDOG_FAULT_OUTPUT_OE
);
    logic        rail_ok, kick_q, wd_on, rst_fixed, kick_fall;
    logic [31:0] ok_cnt_q, flt_cnt_q, win_cnt_q, rst_cyc, up_cyc, lo_cyc;
    assign rail_ok   = POWER_ON_OK && !RAIL_UNDERVOLTAGE && !RAIL_OVERVOLTAGE;
    assign rst_fixed = RESET_DELAY_PIN != STRAP_CAP;
    assign rst_cyc   = (RESET_DELAY_PIN == STRAP_PULLUP) ? RST_PULLUP_CYC : RST_OPEN_CYC;
    assign up_cyc    = (WATCHDOG_TIMING_PIN == STRAP_PULLUP) ? WDU_PULLUP_CYC : WDU_OPEN_CYC;
    assign lo_cyc    = up_cyc >> (WINDOW_SELECT_1 ? (WINDOW_SELECT_0 ? 2 : 1) : 3);
    assign wd_on     = {WINDOW_SELECT_1, WINDOW_SELECT_0} != 2'b01 && WATCHDOG_TIMING_PIN != STRAP_CAP;
    assign kick_fall = kick_q && !WATCHDOG_KICK_INPUT && !RESET_OUT_OE && !WATCHDOG_FAULT_OUTPUT_OE;
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) ok_cnt_q <= '0;
        else if (!rail_ok) ok_cnt_q <= '0;
        else if (ok_cnt_q != '1) ok_cnt_q <= ok_cnt_q + 32'h0000_0001;
    end
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) flt_cnt_q <= '0;
        else flt_cnt_q <= WATCHDOG_FAULT_OUTPUT_OE ? flt_cnt_q + 32'h0000_0001 : '0;
    end
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            win_cnt_q <= '0;
            kick_q    <= 1'b1;
        end else begin
            kick_q    <= WATCHDOG_KICK_INPUT;
            win_cnt_q <= (RESET_OUT_OE || WATCHDOG_FAULT_OUTPUT_OE || kick_fall) ? '0 : win_cnt_q + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    a_rail_bad_reset: assert property (!rail_ok |=> RESET_OUT_OE)
        else $error("reset output not asserted on a bad rail");
    a_delay_min: assert property ($fell(RESET_OUT_OE) && rst_fixed |-> ok_cnt_q >= rst_cyc)
        else $error("reset released before the delay");
    a_delay_max: assert property (rst_fixed && ok_cnt_q == rst_cyc + 6 |-> !RESET_OUT_OE)
        else $error("reset held past the delay");
    a_fault_needs_rel: assert property (WATCHDOG_FAULT_OUTPUT_OE |-> !RESET_OUT_OE)
        else $error("fault output driven during reset");
    a_fault_hold_len: assert property ($fell(WATCHDOG_FAULT_OUTPUT_OE) && !RESET_OUT_OE && rst_fixed
        |-> flt_cnt_q >= rst_cyc && flt_cnt_q <= rst_cyc + 2)
        else $error("fault hold length wrong");
    a_upper_bound: assert property (wd_on |-> win_cnt_q <= up_cyc + 3)
        else $error("window ran past its upper bound");
    a_early_kick: assert property (wd_on && kick_fall && win_cnt_q + 2 < lo_cyc
        |-> ##[1:3] WATCHDOG_FAULT_OUTPUT_OE)
        else $error("early kick not flagged");
    a_valid_kick: assert property (wd_on && kick_fall && win_cnt_q >= lo_cyc + 2
        && win_cnt_q + 4 <= up_cyc |=> !WATCHDOG_FAULT_OUTPUT_OE [*3])
        else $error("valid kick led to a fault");
    a_disabled_quiet: assert property ({WINDOW_SELECT_1, WINDOW_SELECT_0} == 2'b01
        && !WATCHDOG_FAULT_OUTPUT_OE |=> !WATCHDOG_FAULT_OUTPUT_OE)
        else $error("fault raised while disabled");
    c_release: cover property ($fell(RESET_OUT_OE));
    c_fault: cover property ($rose(WATCHDOG_FAULT_OUTPUT_OE));
    c_kick: cover property (wd_on && kick_fall);
endmodule // wwd_top_asserts
bind wwd_top wwd_top_asserts #(
    .RST_PULLUP_CYC(RST_PULLUP_CYC), .RST_OPEN_CYC(RST_OPEN_CYC),
    .WDU_PULLUP_CYC(WDU_PULLUP_CYC), .WDU_OPEN_CYC(WDU_OPEN_CYC)
) i_wwd_chk (.*);
`default_nettype wire

// >>> verif/wwd_top_tb.sv
// Self-checking testbench of the window watchdog reset supervisor.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, want) check_val(32'(got), 32'(want))
module wwd_top_tb import wwd_pkg::*;;
    logic        ref_clk = 1'b0;
    logic        nrst, psel, penable, pwrite, pok, uv, ov, sel0, sel1, host_en;
    logic        pready, pslverr, err, kick, rst_oe, rst_o, flt_oe, flt_o, irq, rst_pin, flt_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] host_per;
    wwd_strap_t  rst_strap, wd_strap;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          n;
    logic [1:0]  sel_tab [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    int          lo_tab  [4] = '{32, 128, 64, 0};
    assign rst_pin = rst_oe ? rst_o : 1'b1;
    assign flt_pin = flt_oe ? flt_o : 1'b1;
    always #20 ref_clk = ~ref_clk;
    wwd_top #(
        .RST_PULLUP_CYC(32'h0000_0040), .RST_OPEN_CYC(32'h0000_0020),
        .WDU_PULLUP_CYC(32'h0000_0200), .WDU_OPEN_CYC(32'h0000_0100)
    ) i_dut (
        .REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .POWER_ON_OK(pok), .RAIL_UNDERVOLTAGE(uv), .RAIL_OVERVOLTAGE(ov),
        .WATCHDOG_KICK_INPUT(kick), .WINDOW_SELECT_0(sel0), .WINDOW_SELECT_1(sel1),
        .RESET_DELAY_PIN(rst_strap), .WATCHDOG_TIMING_PIN(wd_strap), .RESET_OUT_I(rst_pin),
        .RESET_OUT_O(rst_o), .RESET_OUT_OE(rst_oe), .WATCHDOG_FAULT_OUTPUT_I(flt_pin),
        .WATCHDOG_FAULT_OUTPUT_O(flt_o), .WATCHDOG_FAULT_OUTPUT_OE(flt_oe), .IRQ(irq)
    );
    wwd_host_model i_host (.clk(ref_clk), .rst_pin(rst_pin), .enable(host_en), .period(host_per), .kick(kick));
    task automatic test_done();
        $display("counts: checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            mismatches++;
            $display("MISMATCH at %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic wait_pin(input logic fault, input logic lvl);
        n = 0;
        while ((fault ? flt_pin : rst_pin) !== lvl) begin
            @(posedge ref_clk);
            n++;
            if (n > 2000) begin
                mismatches++;
                test_done();
            end
        end
    endtask
    task automatic rail_pulse(input int kind, input wwd_strap_t strap, input logic [1:0] sel, input int want);
        @(posedge ref_clk);
        uv  <= (kind == 0);
        ov  <= (kind == 1);
        pok <= (kind != 2);
        cyc(3);
        `CHECK(rst_pin, 1'b0);
        `CHECK(flt_pin, 1'b1);
        rst_strap    <= strap;
        {sel1, sel0} <= sel;
        cyc(2);
        uv  <= 1'b0;
        ov  <= 1'b0;
        pok <= 1'b1;
        wait_pin(1'b0, 1'b1);
        `CHECK(n >= want && n <= want + 5, 1'b1);
    endtask
    initial begin
        {nrst, psel, penable, pwrite, uv, ov, sel1, sel0} = 8'h00;
        {pok, host_en} = 2'b11;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        host_per = 16'h0090;
        rst_strap = STRAP_OPEN;
        wd_strap = STRAP_OPEN;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_pin(1'b0, 1'b1);
        `CHECK(n >= 32 && n <= 37, 1'b1);
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHECK(rd, 32'h0000_0100);
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHECK(rd, 32'h0000_1000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        `CHECK(rd, 32'h0000_01C1);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHECK(rd, 32'h0000_0002);
        apb(1'b0, 12'h020, 32'h0000_0000);
        `CHECK(err, 1'b1);
        `CHECK(rd, 32'h0000_0000);
        $display("test power_on done");
        for (int k = 0; k < 3; k++) rail_pulse(k, STRAP_OPEN, 2'b00, 32);
        rail_pulse(0, STRAP_PULLUP, 2'b00, 64);
        apb(1'b1, 12'h000, 32'h0000_0030);
        rail_pulse(1, STRAP_CAP, 2'b00, 48);
        cyc(600);
        `CHECK(flt_pin, 1'b1);
        $display("test rail done");
        for (int i = 0; i < 4; i++) begin
            for (int e = 0; e < 2; e++) begin
                host_en  <= (lo_tab[i] != 0);
                host_per <= 16'(e ? lo_tab[i] / 2 : (lo_tab[i] + 256) / 2);
                rail_pulse(0, STRAP_OPEN, sel_tab[i], 32);
                apb(1'b1, 12'h010, 32'h0000_000F);
                cyc(600);
                apb(1'b0, 12'h00C, 32'h0000_0000);
                `CHECK(rd[3:2], (e && lo_tab[i] != 0) ? 2'b01 : 2'b00);
            end
        end
        $display("test window done");
        host_en  <= 1'b0;
        wd_strap <= STRAP_PULLUP;
        apb(1'b1, 12'h014, 32'h0000_0008);
        rail_pulse(0, STRAP_OPEN, 2'b00, 32);
        wait_pin(1'b1, 1'b0);
        `CHECK(n >= 508 && n <= 516, 1'b1);
        `CHECK(rst_pin, 1'b1);
        cyc(2);
        `CHECK(irq, 1'b1);
        wait_pin(1'b1, 1'b1);
        `CHECK(n >= 30 && n <= 35, 1'b1);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHECK(rd[3], 1'b1);
        apb(1'b1, 12'h014, 32'h0000_0000);
        apb(1'b1, 12'h010, 32'h0000_000F);
        cyc(2);
        `CHECK(irq, 1'b0);
        wait_pin(1'b1, 1'b0);
        cyc(2);
        `CHECK(irq, 1'b0);
        apb(1'b1, 12'h014, 32'h0000_0008);
        cyc(2);
        `CHECK(irq, 1'b1);
        apb(1'b1, 12'h010, 32'h0000_0008);
        cyc(2);
        `CHECK(irq, 1'b0);
        apb(1'b1, 12'h004, 32'h0000_0180);
        wd_strap <= STRAP_CAP;
        rail_pulse(0, STRAP_OPEN, 2'b00, 32);
        wait_pin(1'b1, 1'b0);
        `CHECK(n >= 380 && n <= 388, 1'b1);
        $display("test irq done");
        test_done();
    end
endmodule // wwd_top_tb
`default_nettype wire
